// file: design/tkdl_map.svh
`ifndef TKDL_MAP_SVH
`define TKDL_MAP_SVH
`define TKDL_SIG_W 16
`define TKDL_THRESH 16'h000C
`define TKDL_HYST 16'h0002
`define TKDL_NEG_ERR 16'h0005
`define TKDL_DI_LIMIT 3'h6
`define TKDL_CLK_HZ 25000000
`define TKDL_NOM_OSC_HZ 100000
`define TKDL_SLEEP_MS 90
`define TKDL_SYNC_MS 18
`define TKDL_NEG_ERR_MS 2000
`define TKDL_T10_MS 10000
`define TKDL_T60_MS 60000
`define TKDL_OPT_PERIOD_MS 10000
`define TKDL_OPT_SAMPLES 25
`define TKDL_OPT_WIN_US 250
`define TKDL_RISE_DIV 8'h40
`define TKDL_FALL_DIV 8'h04
`define TKDL_FAST_BURST_US 2000
`define TKDL_RECAL_MIN_US 10
`endif

// file: design/tkdl_pkg.sv
package tkdl_pkg;
  typedef enum logic [1:0] {
    TKDL_TO_10S,
    TKDL_TO_60S,
    TKDL_TO_INF
  } tkdl_timeout_t;
  typedef enum {
    TKDL_SLEEP,
    TKDL_BURST
  } tkdl_seq_t;
endpackage

// file: design/tkdl_channel.sv
`timescale 1ns/1ps
`include "tkdl_map.svh"
module tkdl_channel
  import tkdl_pkg::*;
#(
  parameter int SIG_W = `TKDL_SIG_W,
  parameter int TMR_W = 24
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic recal_all,
  input wire logic sample_valid,
  input wire logic [SIG_W-1:0] sample,
  input wire logic drift_tick,
  input wire logic time_tick,
  input wire logic [TMR_W-1:0] max_on_ticks,
  input wire logic timeout_en,
  input wire logic [TMR_W-1:0] neg_err_ticks,
  output logic confirmed,
  output logic pending,
  output logic timeout_recal
);
  // ==========================================
  // reference and comparisons
  logic [SIG_W-1:0] reference;
  logic [2:0] consensus_counter;
  logic [TMR_W-1:0] on_timer;
  logic [TMR_W-1:0] neg_timer;
  logic [7:0] rise_div;
  logic [7:0] fall_div;
  logic calibrated;
  logic above;
  logic below_hyst;
  logic neg_err;
  logic recal_self;
  logic do_recal;
  logic neg_run;

  assign above = sample > reference + `TKDL_THRESH;
  assign below_hyst = sample < reference + `TKDL_THRESH - `TKDL_HYST;
  assign neg_err = sample + `TKDL_NEG_ERR <= reference;
  assign timeout_recal = sample_valid && confirmed && timeout_en && on_timer >= max_on_ticks;
  assign recal_self = sample_valid
    && (timeout_recal || (neg_err && neg_timer >= neg_err_ticks));
  assign do_recal = recal_all || recal_self || (sample_valid && !calibrated);
  assign pending = consensus_counter != 3'h0 && !confirmed;

  // ==========================================
  // reference tracking
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reference <= '0;
      calibrated <= 1'b0;
      rise_div <= 8'h00;
      fall_div <= 8'h00;
    end else if (recal_all) begin
      calibrated <= 1'b0;
    end else if (do_recal && sample_valid) begin
      reference <= sample;
      calibrated <= 1'b1;
      rise_div <= 8'h00;
      fall_div <= 8'h00;
    end else if (drift_tick && !confirmed && consensus_counter == 3'h0) begin
      if (sample > reference) begin
        fall_div <= 8'h00;
        if (rise_div >= `TKDL_RISE_DIV - 8'h01) begin
          rise_div <= 8'h00;
          reference <= reference + 1'b1;
        end else begin
          rise_div <= rise_div + 8'h01;
        end
      end else if (sample < reference) begin
        rise_div <= 8'h00;
        if (fall_div >= `TKDL_FALL_DIV - 8'h01) begin
          fall_div <= 8'h00;
          reference <= reference - 1'b1;
        end else begin
          fall_div <= fall_div + 8'h01;
        end
      end
    end
  end

  // ==========================================
  // consensus filter
  always_ff @(posedge sys_clk) begin
    if (srst || do_recal) begin
      consensus_counter <= 3'h0;
      confirmed <= 1'b0;
    end else if (sample_valid) begin
      if (!confirmed) begin
        if (above) begin
          if (consensus_counter + 3'h1 >= `TKDL_DI_LIMIT) begin
            confirmed <= 1'b1;
            consensus_counter <= `TKDL_DI_LIMIT;
          end else begin
            consensus_counter <= consensus_counter + 3'h1;
          end
        end else begin
          consensus_counter <= 3'h0;
        end
      end else if (below_hyst) begin
        confirmed <= 1'b0;
        consensus_counter <= 3'h0;
      end
    end
  end

  // ==========================================
  // duration timers
  always_ff @(posedge sys_clk) begin
    if (srst || do_recal || !confirmed) begin
      on_timer <= '0;
    end else if (time_tick && on_timer != '1) begin
      on_timer <= on_timer + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || do_recal) begin
      neg_timer <= '0;
      neg_run <= 1'b0;
    end else begin
      // the sample bus only means something at its strobe, so hold the error state
      if (sample_valid) begin
        neg_run <= neg_err;
      end
      if (sample_valid && !neg_err) begin
        neg_timer <= '0;
      end else if (time_tick && (sample_valid || neg_run) && neg_timer != '1) begin
        neg_timer <= neg_timer + 1'b1;
      end
    end
  end
endmodule

// file: design/tkdl_top.sv
`timescale 1ns/1ps
`include "tkdl_map.svh"
// Function
// - Reference drifts toward signal only while the channel has no detection.
// - Reference follows falling signal faster than rising signal.
// - Per-channel slew-limited reference; threshold and hysteresis relative to it.
// - Slow mode without sync times adaptation from the 90 ms sleep interval.
// - Slow mode with sync scales adaptation as if period were 18 ms.
// - Detect above 12 counts over reference; release with 2 count hysteresis.
// - Per-channel max on-duration timeout recalibrates only that channel.
// - Option straps select direct or toggle output and 10s, 60s or infinite.
// - Fast-mode timeouts scale inversely with oscillator frequency.
// - Slow sync mode counts sync periods assuming 18 ms each for timeouts.
// - Consensus counter confirms at six; any miss clears it.
// - Slow mode runs confirming bursts back to back without sleep.
// - Power-up recalibrates all channels before detection.
// - Signal 5 counts below reference for 2 s recalibrates that channel.
// - Straps sampled at power-up and every 10 s while nothing detects.
// - Strap reading is 25 samples over 250 us, all must agree.
// - Rate strap low selects fast mode, high selects slow low-power mode.
// - Sync input honoured only in slow mode.
// - Toggle mode inverts output on confirmed rising edge; timeout keeps state.
// - Slow mode: sync pulse wakes one burst; else wake after 90 ms.
// - Fast mode: sync pin outputs high for one burst, low at burst end.
module tkdl_top
  import tkdl_pkg::*;
#(
  parameter int SIG_W = `TKDL_SIG_W,
  parameter int CLK_HZ = `TKDL_CLK_HZ,
  parameter int SLEEP_CYC = `TKDL_SLEEP_MS * (`TKDL_CLK_HZ / 1000),
  parameter int SYNC_NOM_CYC = `TKDL_SYNC_MS * (`TKDL_CLK_HZ / 1000),
  parameter int FAST_BURST_CYC = `TKDL_FAST_BURST_US * (`TKDL_CLK_HZ / 1000000),
  parameter int MS_CYC = `TKDL_CLK_HZ / 1000,
  parameter int OPT_PERIOD_CYC = `TKDL_OPT_PERIOD_MS * (`TKDL_CLK_HZ / 1000),
  parameter int OPT_GAP_CYC = (`TKDL_OPT_WIN_US * (`TKDL_CLK_HZ / 1000000)) / `TKDL_OPT_SAMPLES,
  parameter int RECAL_MIN_CYC = (`TKDL_RECAL_MIN_US * (`TKDL_CLK_HZ / 1000000)) / 2,
  parameter int OSC_HZ = `TKDL_NOM_OSC_HZ
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic recal_reset_n,
  input wire logic rate_strap,
  input wire logic option_strap_a,
  input wire logic option_strap_b,
  input wire logic sync_in,
  input wire logic sample_valid,
  input wire logic [SIG_W-1:0] sample_a,
  input wire logic [SIG_W-1:0] sample_b,
  output logic burst_req,
  output logic sync_ss_out,
  output logic sync_ss_oe,
  output logic key_a_output,
  output logic key_b_output,
  output logic slow_mode,
  output logic toggle_mode
);
  localparam int TMR_W = 24;
  localparam int CNT_W = 32;
  // ==========================================
  // pin synchronisers
  logic [1:0] res_s, rate_s, opt_a_s, opt_b_s, sync_s;
  logic sync_prev;
  logic sync_rise;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      res_s <= 2'h3;
      rate_s <= 2'h0;
      opt_a_s <= 2'h0;
      opt_b_s <= 2'h0;
      sync_s <= 2'h0;
      sync_prev <= 1'b0;
    end else begin
      res_s <= {res_s[0], recal_reset_n};
      rate_s <= {rate_s[0], rate_strap};
      opt_a_s <= {opt_a_s[0], option_strap_a};
      opt_b_s <= {opt_b_s[0], option_strap_b};
      sync_s <= {sync_s[0], sync_in};
      sync_prev <= sync_s[1];
    end
  end
  assign sync_rise = slow_mode && sync_s[1] && !sync_prev;

  // ==========================================
  // forced recalibration from the reset pin
  logic [CNT_W-1:0] res_low_cnt;
  logic recal_all;
  logic powerup;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      res_low_cnt <= '0;
    end else if (!res_s[1]) begin
      if (res_low_cnt != '1) res_low_cnt <= res_low_cnt + 1'b1;
    end else begin
      res_low_cnt <= '0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      powerup <= 1'b1;
    end else begin
      powerup <= 1'b0;
    end
  end
  // valid pulse of the reset pin recalibrates all channels on release
  assign recal_all = powerup || (res_s[1] && res_low_cnt >= CNT_W'(RECAL_MIN_CYC));

  // ==========================================
  // option strap reading
  logic [CNT_W-1:0] opt_timer;
  logic [CNT_W-1:0] opt_gap;
  logic [4:0] opt_n;
  logic opt_busy, opt_agree;
  logic [2:0] opt_first;
  tkdl_timeout_t timeout_sel;
  logic any_detect;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      opt_timer <= '0;
      opt_busy <= 1'b1;
      opt_gap <= '0;
      opt_n <= 5'h00;
      opt_agree <= 1'b1;
      opt_first <= 3'h0;
    end else if (!opt_busy) begin
      opt_timer <= opt_timer + 1'b1;
      if (opt_timer >= CNT_W'(OPT_PERIOD_CYC) && !any_detect) begin
        opt_busy <= 1'b1;
        opt_timer <= '0;
      end
    end else if (opt_gap < CNT_W'(OPT_GAP_CYC)) begin
      opt_gap <= opt_gap + 1'b1;
    end else begin
      opt_gap <= '0;
      opt_n <= opt_n + 5'h01;
      if (opt_n == 5'h00) begin
        opt_first <= {rate_s[1], opt_a_s[1], opt_b_s[1]};
      end else if (opt_first != {rate_s[1], opt_a_s[1], opt_b_s[1]}) begin
        opt_agree <= 1'b0;
      end
      if (opt_n == 5'(`TKDL_OPT_SAMPLES - 1)) begin
        opt_busy <= 1'b0;
        opt_n <= 5'h00;
        opt_agree <= 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      slow_mode <= 1'b0;
      toggle_mode <= 1'b0;
      timeout_sel <= TKDL_TO_INF;
    end else if (opt_busy && opt_gap == CNT_W'(OPT_GAP_CYC)
                 && opt_n == 5'(`TKDL_OPT_SAMPLES - 1) && opt_agree
                 && opt_first == {rate_s[1], opt_a_s[1], opt_b_s[1]}) begin
      slow_mode <= opt_first[2];
      toggle_mode <= opt_first[1] && opt_first[0];
      case (opt_first[1:0])
        2'h1: timeout_sel <= TKDL_TO_10S;
        2'h2: timeout_sel <= TKDL_TO_60S;
        2'h3: timeout_sel <= TKDL_TO_10S;
        default: timeout_sel <= TKDL_TO_INF;
      endcase
    end
  end

  // ==========================================
  // burst sequencer
  tkdl_seq_t seq;
  logic [CNT_W-1:0] seq_cnt;
  logic sync_seen;
  logic pend_a, pend_b;
  logic burst_done;
  assign burst_done = sample_valid;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync_seen <= 1'b0;
    end else if (!slow_mode) begin
      sync_seen <= 1'b0;
    end else if (sync_rise) begin
      sync_seen <= 1'b1;
    end else if (seq == TKDL_SLEEP && seq_cnt >= CNT_W'(SLEEP_CYC - 1)) begin
      sync_seen <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      seq <= TKDL_SLEEP;
      seq_cnt <= '0;
    end else begin
      case (seq)
        TKDL_SLEEP: begin
          seq_cnt <= seq_cnt + 1'b1;
          if (!slow_mode || pend_a || pend_b || sync_rise
              || seq_cnt >= CNT_W'(SLEEP_CYC - 1)) begin
            seq <= TKDL_BURST;
            seq_cnt <= '0;
          end
        end
        TKDL_BURST: begin
          seq_cnt <= seq_cnt + 1'b1;
          if (burst_done) begin
            seq <= TKDL_SLEEP;
            seq_cnt <= '0;
          end
        end
        default: seq <= TKDL_SLEEP;
      endcase
    end
  end
  assign burst_req = seq == TKDL_BURST;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync_ss_out <= 1'b0;
      sync_ss_oe <= 1'b0;
    end else begin
      sync_ss_oe <= !slow_mode;
      sync_ss_out <= !slow_mode && seq == TKDL_BURST && !burst_done;
    end
  end

  // ==========================================
  // time bases for drift and timeouts
  logic [CNT_W-1:0] ms_cnt;
  logic [CNT_W-1:0] ms_step;
  logic [CNT_W-1:0] ms_sum;
  logic ms_tick;
  logic [2:0] drift_sub;
  logic time_tick;
  logic drift_tick;
  logic [TMR_W-1:0] max_on_ticks;
  logic [TMR_W-1:0] neg_err_ticks;
  // slow mode counts bursts; fast mode counts milliseconds of the oscillator
  assign ms_step = slow_mode ? '0 : CNT_W'(OSC_HZ / `TKDL_NOM_OSC_HZ);
  assign ms_sum = ms_cnt + ms_step;
  assign ms_tick = ms_sum >= CNT_W'(MS_CYC);
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ms_cnt <= '0;
    end else if (ms_tick) begin
      // keep the remainder so a scaled step loses no time
      ms_cnt <= ms_sum - CNT_W'(MS_CYC);
    end else begin
      ms_cnt <= ms_sum;
    end
  end
  // with sync, one drift step per nominal sleep interval worth of sync periods
  always_ff @(posedge sys_clk) begin
    if (srst || !sync_seen) begin
      drift_sub <= 3'h0;
    end else if (sample_valid) begin
      drift_sub <= (drift_sub >= 3'(`TKDL_SLEEP_MS / `TKDL_SYNC_MS - 1)) ? 3'h0 : drift_sub + 3'h1;
    end
  end
  assign drift_tick = sample_valid && (!sync_seen || drift_sub == 3'h0);
  assign time_tick = slow_mode ? sample_valid : ms_tick;
  always_comb begin
    if (slow_mode) begin
      // one burst stands for the nominal sleep or sync period
      max_on_ticks = (timeout_sel == TKDL_TO_60S)
        ? TMR_W'(`TKDL_T60_MS / (`TKDL_SLEEP_MS)) : TMR_W'(`TKDL_T10_MS / (`TKDL_SLEEP_MS));
      neg_err_ticks = TMR_W'(`TKDL_NEG_ERR_MS / `TKDL_SLEEP_MS);
      if (sync_seen) begin
        max_on_ticks = (timeout_sel == TKDL_TO_60S)
          ? TMR_W'(`TKDL_T60_MS / `TKDL_SYNC_MS) : TMR_W'(`TKDL_T10_MS / `TKDL_SYNC_MS);
        neg_err_ticks = TMR_W'(`TKDL_NEG_ERR_MS / `TKDL_SYNC_MS);
      end
    end else begin
      max_on_ticks = (timeout_sel == TKDL_TO_60S) ? TMR_W'(`TKDL_T60_MS) : TMR_W'(`TKDL_T10_MS);
      neg_err_ticks = TMR_W'(`TKDL_NEG_ERR_MS);
    end
  end

  // ==========================================
  // channels and outputs
  logic conf_a, conf_b, conf_a_d, conf_b_d;
  tkdl_channel #(.SIG_W(SIG_W), .TMR_W(TMR_W)) u_ch_a (
    .sys_clk(sys_clk), .srst(srst), .recal_all(recal_all),
    .sample_valid(sample_valid), .sample(sample_a),
    .drift_tick(drift_tick), .time_tick(time_tick),
    .max_on_ticks(max_on_ticks), .timeout_en(timeout_sel != TKDL_TO_INF),
    .neg_err_ticks(neg_err_ticks),
    .confirmed(conf_a), .pending(pend_a), .timeout_recal()
  );
  tkdl_channel #(.SIG_W(SIG_W), .TMR_W(TMR_W)) u_ch_b (
    .sys_clk(sys_clk), .srst(srst), .recal_all(recal_all),
    .sample_valid(sample_valid), .sample(sample_b),
    .drift_tick(drift_tick), .time_tick(time_tick),
    .max_on_ticks(max_on_ticks), .timeout_en(timeout_sel != TKDL_TO_INF),
    .neg_err_ticks(neg_err_ticks),
    .confirmed(conf_b), .pending(pend_b), .timeout_recal()
  );
  assign any_detect = conf_a || conf_b || pend_a || pend_b;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      conf_a_d <= 1'b0;
      conf_b_d <= 1'b0;
      key_a_output <= 1'b0;
      key_b_output <= 1'b0;
    end else begin
      conf_a_d <= conf_a;
      conf_b_d <= conf_b;
      if (toggle_mode) begin
        if (conf_a && !conf_a_d) key_a_output <= !key_a_output;
        if (conf_b && !conf_b_d) key_b_output <= !key_b_output;
      end else begin
        key_a_output <= conf_a;
        key_b_output <= conf_b;
      end
    end
  end
endmodule

// file: dv/tkdl_top_props.sv
`timescale 1ns/1ps
// ====================================================================
// port-level checks of the touch key block
module tkdl_top_chk (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic rate_strap,
  input wire logic option_strap_a,
  input wire logic option_strap_b,
  input wire logic sample_valid,
  input wire logic sync_ss_oe,
  input wire logic key_a_output,
  input wire logic key_b_output,
  input wire logic slow_mode,
  input wire logic toggle_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_fast3;
    !slow_mode [*3];
  endsequence
  sequence s_slow3;
    slow_mode [*3];
  endsequence
  sequence s_tog4;
    toggle_mode [*4];
  endsequence

  property p_key_a_rise;
    $rose(key_a_output) |-> $past(sample_valid, 2);
  endproperty
  property p_key_b_rise;
    $rose(key_b_output) |-> $past(sample_valid, 2);
  endproperty
  property p_tog_a;
    s_tog4 ##0 $changed(key_a_output) |-> $past(sample_valid, 2);
  endproperty
  property p_tog_b;
    s_tog4 ##0 $changed(key_b_output) |-> $past(sample_valid, 2);
  endproperty
  property p_oe_fast;
    s_fast3 |-> sync_ss_oe;
  endproperty
  property p_oe_slow;
    s_slow3 |-> !sync_ss_oe;
  endproperty
  property p_slow_src;
    $changed(slow_mode) |-> slow_mode == rate_strap && slow_mode == $past(rate_strap, 200);
  endproperty
  property p_tog_src;
    $changed(toggle_mode) |->
      toggle_mode == ($past(option_strap_a, 200) & $past(option_strap_b, 200));
  endproperty
  property p_opt_idle;
    $changed(toggle_mode) |-> !$past(key_a_output) && !$past(key_b_output);
  endproperty

  a_key_a_rise: assert property (p_key_a_rise)
    else $error("key a rose with no sample two cycles before");
  a_key_b_rise: assert property (p_key_b_rise)
    else $error("key b rose with no sample two cycles before");
  a_tog_a: assert property (p_tog_a)
    else $error("toggle key a moved without a sample");
  a_tog_b: assert property (p_tog_b)
    else $error("toggle key b moved without a sample");
  a_oe_fast: assert property (p_oe_fast)
    else $error("sync pin not driven in fast mode");
  a_oe_slow: assert property (p_oe_slow)
    else $error("sync pin driven in slow mode");
  a_slow_src: assert property (p_slow_src)
    else $error("speed mode differs from strap");
  a_tog_src: assert property (p_tog_src)
    else $error("output mode differs from straps");
  a_opt_idle: assert property (p_opt_idle)
    else $error("options changed while a key was on");
endmodule

bind tkdl_top tkdl_top_chk chk_u (
  .sys_clk(sys_clk), .srst(srst), .rate_strap(rate_strap),
  .option_strap_a(option_strap_a), .option_strap_b(option_strap_b),
  .sample_valid(sample_valid), .sync_ss_oe(sync_ss_oe),
  .key_a_output(key_a_output), .key_b_output(key_b_output),
  .slow_mode(slow_mode), .toggle_mode(toggle_mode)
);

// file: dv/tkdl_front_model.sv
`timescale 1ns/1ps
// ====================================================================
// acquisition front end: one sample pair per requested burst
module tkdl_front_model #(
  parameter int BURST_CYC = 20
) (
  input wire logic sys_clk,
  input wire logic burst_req,
  input wire logic [15:0] level_a,
  input wire logic [15:0] level_b,
  output logic sample_valid,
  output logic [15:0] sample_a,
  output logic [15:0] sample_b,
  output int n_smp
);
  int cnt = 0;
  initial begin
    sample_valid = 1'b0;
    sample_a = 16'h0000;
    sample_b = 16'h0000;
    n_smp = 0;
  end
  always @(negedge sys_clk) begin
    sample_valid <= 1'b0;
    if (sample_valid) begin
      // data is not held past its strobe
      sample_a <= ~sample_a;
      sample_b <= ~sample_b;
    end else if (burst_req) begin
      if (cnt == BURST_CYC - 1) begin
        sample_valid <= 1'b1;
        sample_a <= level_a;
        sample_b <= level_b;
        n_smp <= n_smp + 1;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic recal_reset_n = 1'b1;
  logic rate_strap = 1'b0;
  logic option_strap_a = 1'b0;
  logic option_strap_b = 1'b1;
  logic sync_in = 1'b0;
  logic sample_valid, burst_req, sync_ss_out, sync_ss_oe;
  logic key_a_output, key_b_output, slow_mode, toggle_mode;
  logic [15:0] sample_a, sample_b;
  logic [15:0] lv_a = 16'h03E8;
  logic [15:0] lv_b = 16'h03E8;
  int n_smp;
  int n_fail = 0;
  int checked = 0;

  always #20 sys_clk = ~sys_clk;

  tkdl_top #(.SLEEP_CYC(3000), .MS_CYC(2), .OPT_PERIOD_CYC(8000)) dut_u (
    .sys_clk(sys_clk), .srst(srst), .recal_reset_n(recal_reset_n),
    .rate_strap(rate_strap), .option_strap_a(option_strap_a),
    .option_strap_b(option_strap_b), .sync_in(sync_in), .sample_valid(sample_valid),
    .sample_a(sample_a), .sample_b(sample_b), .burst_req(burst_req),
    .sync_ss_out(sync_ss_out), .sync_ss_oe(sync_ss_oe), .key_a_output(key_a_output),
    .key_b_output(key_b_output), .slow_mode(slow_mode), .toggle_mode(toggle_mode)
  );

  tkdl_front_model fm_u (
    .sys_clk(sys_clk), .burst_req(burst_req), .level_a(lv_a), .level_b(lv_b),
    .sample_valid(sample_valid), .sample_a(sample_a), .sample_b(sample_b), .n_smp(n_smp)
  );

  // ==================================================================
  // tasks
  task results();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return key_a_output;
      1: return key_b_output;
      2: return toggle_mode;
      3: return slow_mode;
      5: return sync_ss_out;
      default: return burst_req;
    endcase
  endfunction

  // bounded wait for an output level, then compare it
  task wt(input int s, input logic v, input int lim);
    for (int i = 0; i < lim && sig(s) !== v; i++) begin
      @(negedge sys_clk);
    end
    chk(sig(s), v);
    if (sig(s) !== v) begin
      results();
    end
  endtask

  // set electrode levels, let n sample pairs pass, then settle
  task smp(input int n, input logic [15:0] a, input logic [15:0] b);
    int t;
    @(posedge sys_clk);
    lv_a <= a;
    lv_b <= b;
    t = n_smp + n;
    for (int i = 0; i < 40 * n + 40 && n_smp < t; i++) begin
      @(posedge sys_clk);
    end
    chk(n_smp >= t, 1'b1);
    if (n_smp < t) begin
      results();
    end
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task done(input string s);
    $display("test %s done", s);
  endtask

  // ==================================================================
  // scenarios
  initial begin
    repeat (5) @(negedge sys_clk);
    chk(key_a_output, 1'b0);
    chk(slow_mode, 1'b0);
    srst = 1'b0;
    done("reset");
    repeat (7000) @(negedge sys_clk);
    chk(slow_mode, 1'b0);
    chk(toggle_mode, 1'b0);
    chk(sync_ss_oe, 1'b1);
    wt(5, 1'b1, 40);
    wt(5, 1'b0, 40);
    done("straps");
    smp(8, 16'h03F4, 16'h03E8);
    chk(key_a_output, 1'b0);
    smp(5, 16'h0406, 16'h03E8);
    smp(1, 16'h03E8, 16'h03E8);
    smp(5, 16'h0406, 16'h03E8);
    chk(key_a_output, 1'b0);
    smp(1, 16'h0406, 16'h03E8);
    chk(key_a_output, 1'b1);
    chk(key_b_output, 1'b0);
    smp(4, 16'h03F3, 16'h03E8);
    chk(key_a_output, 1'b1);
    smp(6, 16'h03F1, 16'h03E8);
    chk(key_a_output, 1'b0);
    done("detect");
    smp(60, 16'h03DE, 16'h03E8);
    smp(6, 16'h03EC, 16'h03E8);
    chk(key_a_output, 1'b1);
    smp(6, 16'h03DE, 16'h03E8);
    chk(key_a_output, 1'b0);
    done("drift");
    smp(6, 16'h03F2, 16'h03E8);
    chk(key_a_output, 1'b1);
    repeat (5000) @(negedge sys_clk);
    smp(6, 16'h03F2, 16'h03FC);
    chk(key_b_output, 1'b1);
    wt(0, 1'b0, 22000);
    chk(key_b_output, 1'b1);
    smp(6, 16'h03F2, 16'h03E8);
    chk(key_a_output, 1'b0);
    done("timeout");
    smp(1, 16'h04B0, 16'h03E8);
    recal_reset_n = 1'b0;
    repeat (300) @(negedge sys_clk);
    recal_reset_n = 1'b1;
    smp(10, 16'h04B0, 16'h03E8);
    chk(key_a_output, 1'b0);
    done("recal");
    option_strap_a = 1'b1;
    wt(2, 1'b1, 22000);
    smp(6, 16'h04CE, 16'h03FC);
    chk(key_a_output, 1'b1);
    chk(key_b_output, 1'b1);
    smp(6, 16'h04B0, 16'h03E8);
    chk(key_a_output, 1'b1);
    chk(key_b_output, 1'b1);
    smp(6, 16'h04CE, 16'h03FC);
    chk(key_a_output, 1'b0);
    chk(key_b_output, 1'b0);
    smp(6, 16'h04B0, 16'h03E8);
    chk(key_a_output, 1'b0);
    done("toggle");
    rate_strap = 1'b1;
    option_strap_b = 1'b0;
    wt(3, 1'b1, 22000);
    repeat (3) @(negedge sys_clk);
    chk(toggle_mode, 1'b0);
    chk(sync_ss_oe, 1'b0);
    wt(4, 1'b0, 4000);
    sync_in = 1'b1;
    @(negedge sys_clk);
    sync_in = 1'b0;
    wt(4, 1'b1, 20);
    wt(4, 1'b0, 100);
    wt(4, 1'b1, 3200);
    lv_a <= 16'h04CE;
    wt(0, 1'b1, 3400);
    done("slow");
    results();
  end
endmodule
